// ### rtl/ptd_pkg.sv
// Package with constants, layouts and carrier types of the texel block decoder.
package ptd_pkg;

    // Request and result carriers.
    typedef struct packed {
        logic [63:0] block;
        logic [1:0]  x;
        logic [1:0]  y;
    } ptd_req_s;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic [7:0] alpha;
    } ptd_texel_s;

    // Decode modes, one-hot.
    typedef enum logic [3:0] {
        PTD_MODE_DIFF   = 4'b0001,
        PTD_MODE_T      = 4'b0010,
        PTD_MODE_H      = 4'b0100,
        PTD_MODE_PLANAR = 4'b1000
    } ptd_mode_e;

    // Shared field positions of the block word.
    localparam int SOLID_FLAG_BIT   = 33;
    localparam int SPLIT_BIT        = 32;
    localparam int TABLE1_LSB       = 37;
    localparam int TABLE2_LSB       = 34;
    localparam int INDEX_MSB_OFFSET = 16;

    // Register map, byte addresses.
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_DIST_BASE = 8'h20;
    localparam logic [7:0] REG_DIST_LAST = 8'h3c;

    // Values after reset.
    localparam logic       CTRL_ENABLE_RESET = 1'b1;
    localparam logic [7:0] DIST_RESET        = 8'h00;

    // Modifier magnitudes indexed by table selector.
    localparam logic [7:0] MOD_LARGE [8] = '{8'h08, 8'h11, 8'h1d, 8'h2a,
                                             8'h3c, 8'h50, 8'h6a, 8'hb7};
    localparam logic [7:0] MOD_SMALL [8] = '{8'h02, 8'h05, 8'h09, 8'h0d,
                                             8'h12, 8'h18, 8'h21, 8'h2f};

    localparam logic [7:0] BYTE_MAX = 8'hff;

endpackage : ptd_pkg

// ### rtl/ptd_decoder.sv
// Punch-through texel block decoder with a Wishbone register slave.
//
// How it works
// - Mode from 5-bit value plus signed delta: T, else H, else planar, else diff.
// - Differential halves: split bit zero splits by x, one splits by y.
// - Five-bit values widen to eight by copying the top three bits below.
// - First half uses widened values, second half widened value-plus-delta sums.
// - Table selector of first half is bits 39..37, second half bits 36..34.
// - Selector chooses one of eight fixed modifier sets; solid flag picks family.
// - Solid flag set: small and large magnitudes from the full table.
// - Solid flag clear: same large magnitudes, small entries become zero.
// - Texel index low bit at position p, high bit sixteen above, orientation-free.
// - Solid set: 11 large negative, 10 small negative, 00 small positive, 01 large.
// - Solid clear: 11 large negative, 01 large positive, 10 and 00 zero.
// - Differential adds modifier to each channel, then clamps to 0..255.
// - Diff, T, H: alpha 255 unless solid clear and index 10, then all zero.
// - T and H widen nibbles by doubling and rebuild split fields by concatenation.
// - T distance index is two-bit field above the one-bit field.
// - T paints: base1, base2 plus d, base2, base2 minus d, clamped.
// - H distance index low bit set when packed first colour is at least second.
// - H paints: base1 plus and minus d, base2 plus and minus d, clamped.
// - T and H texels take the paint colour numbered by their index.
// - Planar ignores the solid flag and always gives alpha 255.
// - Planar colours are 6-7-6 from split fields, widened by top-bit copies.
// - Planar channel is (x(H-O)+y(V-O)+4O+2)>>2, clamped to 0..255.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps

module ptd_decoder
    import ptd_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        reset,
    // Request stream.
    input  wire logic        in_valid,
    input  wire ptd_req_s    in_req,
    output logic             in_ready,
    // Result stream.
    output logic             out_valid,
    output ptd_texel_s       out_texel,
    input  wire logic        out_ready,
    // Wishbone register slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    // Widens a five-bit value to a byte.
    function automatic logic [7:0] five_bit_widen(input logic [4:0] v);
        return {v, v[4:2]};
    endfunction : five_bit_widen

    // Widens a four-bit value to a byte.
    function automatic logic [7:0] nibble_replicate(input logic [3:0] v);
        return {v, v};
    endfunction : nibble_replicate

    // Clamps a signed sum into a byte.
    function automatic logic [7:0] saturate_byte(input logic signed [12:0] v);
        if (v < 13'sd0) begin
            return 8'h00;
        end else if (v > 13'sd255) begin
            return BYTE_MAX;
        end
        return v[7:0];
    endfunction : saturate_byte

    // Adds or subtracts a distance on all three channels of a colour.
    function automatic logic [23:0] shift_colour(input logic [23:0] c, input logic [7:0] d,
                                                 input logic neg);
        logic signed [12:0] dd;
        logic [23:0]        r;
        dd = neg ? -$signed({5'h00, d}) : $signed({5'h00, d});
        r  = '0;
        for (int i = 0; i < 3; i++) begin
            r[i*8 +: 8] = saturate_byte($signed({5'h00, c[i*8 +: 8]}) + dd);
        end
        return r;
    endfunction : shift_colour

    // Picks the modifier for a selector, index and solid flag.
    function automatic logic signed [12:0] modifier(input logic [2:0] sel, input logic [1:0] idx,
                                                    input logic solid);
        logic signed [12:0] big_mag;
        logic signed [12:0] small_mag;
        big_mag   = $signed({5'h00, MOD_LARGE[sel]});
        small_mag = solid ? $signed({5'h00, MOD_SMALL[sel]}) : 13'sd0;
        case (idx)
            2'b11:   return -big_mag;
            2'b10:   return -small_mag;
            2'b00:   return small_mag;
            default: return big_mag;
        endcase
    endfunction : modifier

    // Works out one planar channel from widened origin, horizontal and vertical.
    function automatic logic [7:0] planar_chan(input logic [7:0] o, input logic [7:0] h,
                                               input logic [7:0] v, input logic [1:0] x,
                                               input logic [1:0] y);
        logic signed [12:0] s;
        s = $signed({11'h000, x}) * ($signed({5'h00, h}) - $signed({5'h00, o}))
          + $signed({11'h000, y}) * ($signed({5'h00, v}) - $signed({5'h00, o}))
          + ($signed({5'h00, o}) <<< 2) + 13'sd2;
        return saturate_byte(s >>> 2);
    endfunction : planar_chan

    // Registers.
    logic        in_ready_reg;
    logic        out_valid_reg;
    ptd_texel_s  out_texel_reg;
    logic        wb_ack_reg;
    logic [31:0] wb_dat_reg;
    logic        enable_reg;
    logic [7:0]  dist_reg [8];
    logic [15:0] count_reg;
    ptd_mode_e   last_mode_reg;

    // Field extraction and mode choice.
    wire logic [63:0] blk    = in_req.block;
    wire logic        solid  = blk[SOLID_FLAG_BIT];
    wire logic [3:0]  pos    = {in_req.x, in_req.y};
    wire logic [1:0]  idx    = {blk[INDEX_MSB_OFFSET + pos], blk[pos]};
    wire logic [6:0]  sum_r  = {2'b00, blk[63:59]} + {{4{blk[58]}}, blk[58:56]};
    wire logic [6:0]  sum_g  = {2'b00, blk[55:51]} + {{4{blk[50]}}, blk[50:48]};
    wire logic [6:0]  sum_b  = {2'b00, blk[47:43]} + {{4{blk[42]}}, blk[42:40]};
    wire logic        out_r  = sum_r[6] | sum_r[5];
    wire logic        out_g  = sum_g[6] | sum_g[5];
    wire logic        out_b  = sum_b[6] | sum_b[5];
    wire ptd_mode_e   mode   = ptd_mode_e'(out_r ? PTD_MODE_T : out_g ? PTD_MODE_H :
                               out_b ? PTD_MODE_PLANAR : PTD_MODE_DIFF);

    // Differential mode.
    wire logic        second = blk[SPLIT_BIT] ? in_req.y[1] : in_req.x[1];
    wire logic [2:0]  sel    = second ? blk[TABLE2_LSB +: 3] : blk[TABLE1_LSB +: 3];
    wire logic [14:0] b5     = second ? {sum_r[4:0], sum_g[4:0], sum_b[4:0]}
                                      : {blk[63:59], blk[55:51], blk[47:43]};
    wire logic [23:0] d_base = {five_bit_widen(b5[14:10]), five_bit_widen(b5[9:5]),
                                five_bit_widen(b5[4:0])};
    wire logic signed [12:0] mod = modifier(sel, idx, solid);
    wire logic [23:0] d_col  = {saturate_byte($signed({5'h00, d_base[23:16]}) + mod),
                                saturate_byte($signed({5'h00, d_base[15:8]}) + mod),
                                saturate_byte($signed({5'h00, d_base[7:0]}) + mod)};

    // T mode.
    wire logic [23:0] t_b1   = {nibble_replicate({blk[60:59], blk[57:56]}),
                                nibble_replicate(blk[55:52]), nibble_replicate(blk[51:48])};
    wire logic [23:0] t_b2   = {nibble_replicate(blk[47:44]), nibble_replicate(blk[43:40]),
                                nibble_replicate(blk[39:36])};
    wire logic [2:0]  t_di   = {blk[35:34], blk[32]};
    wire logic [7:0]  t_d    = dist_reg[t_di];
    wire logic [23:0] t_col  = (idx == 2'd0) ? t_b1 :
                               (idx == 2'd1) ? shift_colour(t_b2, t_d, 1'b0) :
                               (idx == 2'd2) ? t_b2 : shift_colour(t_b2, t_d, 1'b1);

    // H mode.
    wire logic [23:0] h_b1   = {nibble_replicate(blk[62:59]),
                                nibble_replicate({blk[58:56], blk[52]}),
                                nibble_replicate({blk[51], blk[49:47]})};
    wire logic [23:0] h_b2   = {nibble_replicate(blk[46:43]), nibble_replicate(blk[42:39]),
                                nibble_replicate(blk[38:35])};
    wire logic [2:0]  h_di   = {blk[34], blk[32], h_b1 >= h_b2};
    wire logic [7:0]  h_d    = dist_reg[h_di];
    wire logic [23:0] h_col  = shift_colour(idx[1] ? h_b2 : h_b1, h_d,
                                            idx[0]);

    // Planar mode.
    wire logic [5:0]  p_ro   = blk[62:57];
    wire logic [6:0]  p_go   = {blk[56], blk[54:49]};
    wire logic [5:0]  p_bo   = {blk[48], blk[44:43], blk[41:39]};
    wire logic [5:0]  p_rh   = {blk[38:34], blk[32]};
    wire logic [6:0]  p_gh   = blk[31:25];
    wire logic [5:0]  p_bh   = blk[24:19];
    wire logic [5:0]  p_rv   = blk[18:13];
    wire logic [6:0]  p_gv   = blk[12:6];
    wire logic [5:0]  p_bv   = blk[5:0];
    wire logic [23:0] p_col  = {
        planar_chan({p_ro, p_ro[5:4]}, {p_rh, p_rh[5:4]}, {p_rv, p_rv[5:4]}, in_req.x, in_req.y),
        planar_chan({p_go, p_go[6]}, {p_gh, p_gh[6]}, {p_gv, p_gv[6]}, in_req.x, in_req.y),
        planar_chan({p_bo, p_bo[5:4]}, {p_bh, p_bh[5:4]}, {p_bv, p_bv[5:4]}, in_req.x, in_req.y)};

    // Result selection and punch-through; planar ignores the solid flag.
    wire logic        punch  = !solid && (idx == 2'b10) && (mode != PTD_MODE_PLANAR);
    wire logic [23:0] rgb    = (mode == PTD_MODE_T) ? t_col : (mode == PTD_MODE_H) ? h_col :
                               (mode == PTD_MODE_PLANAR) ? p_col : d_col;
    wire ptd_texel_s  texel  = punch ? '0 : {rgb, BYTE_MAX};

    // Stream handshake: one result slot, refilled only once drained.
    wire logic        accept     = in_valid && in_ready_reg;
    wire logic        drain      = out_valid_reg && out_ready;
    wire logic        valid_next = accept || (out_valid_reg && !out_ready);
    wire logic        ready_next = enable_reg && !valid_next;

    // Register decode.
    wire logic        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_reg;
    wire logic        wb_wr    = wb_req && wb_we_i && wb_sel_i[0];
    wire logic        hit_dist = (wb_adr_i >= REG_DIST_BASE) && (wb_adr_i <= REG_DIST_LAST) &&
                                 (wb_adr_i[1:0] == 2'b00);
    wire logic [2:0]  dist_sel = wb_adr_i[4:2];
    wire logic [31:0] rd_data  = (wb_adr_i == REG_CTRL) ? {31'h0, enable_reg} :
                                 (wb_adr_i == REG_STATUS) ?
                                     {count_reg, 8'h00, last_mode_reg, 3'h0, out_valid_reg} :
                                 hit_dist ? {24'h0, dist_reg[dist_sel]} : 32'h0;

    // Stream state.
    always_ff @(posedge clock) begin
        if (reset) begin
            out_valid_reg <= 1'b0;
            in_ready_reg  <= 1'b0;
            out_texel_reg <= '0;
            last_mode_reg <= PTD_MODE_DIFF;
            count_reg     <= 16'h0000;
        end else begin
            out_valid_reg <= valid_next;
            in_ready_reg  <= ready_next;
            if (accept) begin
                out_texel_reg <= texel;
                last_mode_reg <= mode;
            end
            if (drain) begin
                count_reg <= count_reg + 16'h0001;
            end
        end
    end

    // Register slave: ack one cycle after the request, dropped the next cycle.
    always_ff @(posedge clock) begin
        if (reset) begin
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= 32'h0;
            enable_reg <= CTRL_ENABLE_RESET;
            dist_reg   <= '{default: DIST_RESET};
        end else begin
            wb_ack_reg <= wb_req;
            if (wb_req) begin
                wb_dat_reg <= rd_data;
            end
            if (wb_wr && wb_adr_i == REG_CTRL) begin
                enable_reg <= wb_dat_i[0];
            end
            if (wb_wr && hit_dist) begin
                dist_reg[dist_sel] <= wb_dat_i[7:0];
            end
        end
    end

    // Outputs.
    assign in_ready  = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_texel = out_texel_reg;
    assign wb_ack_o  = wb_ack_reg;
    assign wb_dat_o  = wb_dat_reg;

    // Checks.
    sequence s_accept;
        accept;
    endsequence

    sequence s_stall;
        out_valid_reg && !out_ready;
    endsequence

    a_result_follows: assert property (@(posedge clock) disable iff (reset)
        s_accept |=> out_valid_reg && !in_ready_reg)
        else $error("Accepted request gave no result.");

    a_result_held: assert property (@(posedge clock) disable iff (reset)
        s_stall |=> out_valid_reg && $stable(out_texel_reg))
        else $error("Stalled result changed.");

    a_punch_zero: assert property (@(posedge clock) disable iff (reset)
        s_accept ##0 (!solid && idx == 2'b10 && mode != PTD_MODE_PLANAR) |=> out_texel_reg == '0)
        else $error("Punch-through texel not zero.");

    a_planar_alpha: assert property (@(posedge clock) disable iff (reset)
        s_accept ##0 (mode == PTD_MODE_PLANAR) |=> out_texel_reg.alpha == 8'hff)
        else $error("Planar alpha not 255.");

    a_diff_zero_mod: assert property (@(posedge clock) disable iff (reset)
        s_accept ##0 (mode == PTD_MODE_DIFF && !solid && idx == 2'b00)
        |=> out_texel_reg[31:8] == $past(d_base))
        else $error("Zero modifier changed the base colour.");

    a_t_paint_two: assert property (@(posedge clock) disable iff (reset)
        s_accept ##0 (mode == PTD_MODE_T && solid && idx == 2'b10)
        |=> out_texel_reg[31:8] == $past(t_b2))
        else $error("T paint colour 2 is not the second base.");

    a_widen_five: assert property (@(posedge clock) disable iff (reset)
        d_base[23:16] == {b5[14:10], b5[14:12]})
        else $error("Five-bit widening wrong.");

    a_ack_pulse: assert property (@(posedge clock) disable iff (reset)
        wb_ack_reg |=> !wb_ack_reg)
        else $error("Ack held longer than one cycle.");

    a_disabled_idle: assert property (@(posedge clock) disable iff (reset)
        !enable_reg |=> !in_ready_reg)
        else $error("Ready while disabled.");

    // A held result blocks new requests, so results never overtake one another.
    a_ready_blocked: assert property (@(posedge clock) disable iff (reset)
        out_valid_reg |-> !in_ready_reg)
        else $error("Ready while a result is held.");

    // Every bus request is answered on the very next edge.
    a_ack_follows: assert property (@(posedge clock) disable iff (reset)
        wb_req |=> wb_ack_reg)
        else $error("Bus request not answered.");

    // The delivered count steps once for every drained result.
    a_count_step: assert property (@(posedge clock) disable iff (reset)
        drain |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("Delivered count did not step.");

endmodule : ptd_decoder

// ### testbench/ptd_sampler_model.sv
// Model of the texture sampling unit that feeds blocks and drains texels.
`timescale 1ns/1ps

module ptd_sampler_model
    import ptd_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        reset,
    // Request side.
    output logic             in_valid,
    output ptd_req_s         in_req,
    input  wire logic        in_ready,
    // Result side.
    input  wire logic        out_valid,
    input  wire ptd_texel_s  out_texel,
    output logic             out_ready,
    // Stall control from the bench.
    input  wire logic        stall_en
);
    ptd_texel_s got_q [$];
    logic [3:0] tick = 4'h0;

    // Idle values at time zero.
    initial begin
        in_valid = 1'b0;
        in_req = '0;
        out_ready = 1'b0;
    end

    // Presents one request and holds it until the edge that takes it; the idle bus shows junk.
    task automatic send(input ptd_req_s r);
        @(posedge clock);
        in_valid <= 1'b1;
        in_req <= r;
        do @(posedge clock); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        in_req <= ~r;
    endtask : send

    // Drains results, ready only one cycle in four while stalling.
    always @(posedge clock) begin
        tick <= reset ? 4'h0 : tick + 4'h1;
        out_ready <= !stall_en || tick[1:0] == 2'b00;
        if (!reset && out_valid === 1'b1 && out_ready === 1'b1) begin
            got_q.push_back(out_texel);
        end
    end
endmodule : ptd_sampler_model

// ### testbench/ptd_decoder_tb.sv
// Self-checking bench of the texel block decoder.
`timescale 1ns/1ps

module ptd_decoder_tb
    import ptd_pkg::*;
;
    logic        clock, reset, in_valid, in_ready, out_valid, out_ready, stall_en;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, g, e;
    logic [31:0] seed = 32'h8209;
    logic [3:0]  wb_sel_i;
    ptd_req_s    in_req, rq;
    ptd_texel_s  out_texel;
    logic [7:0]  dtab [8];
    logic [31:0] exp_q [$];
    int          err_count = 0, samples_checked = 0, cycles = 0, n;
    int          lg [8] = '{8, 17, 29, 42, 60, 80, 106, 183};
    int          sm [8] = '{2, 5, 9, 13, 18, 24, 33, 47};

    ptd_decoder i_ptd_decoder (.clock(clock), .reset(reset), .in_valid(in_valid),
        .in_req(in_req), .in_ready(in_ready), .out_valid(out_valid), .out_texel(out_texel),
        .out_ready(out_ready), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o));
    ptd_sampler_model i_ptd_sampler_model (.clock(clock), .reset(reset), .in_valid(in_valid),
        .in_req(in_req), .in_ready(in_ready), .out_valid(out_valid), .out_texel(out_texel),
        .out_ready(out_ready), .stall_en(stall_en));

    // Free-running clock of 5 ns.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Cuts a hang short.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // Steps the shift register 32 times so each draw is fresh.
    function automatic logic [31:0] lfsr();
        for (int k = 0; k < 32; k++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : lfsr

    // Widens an n-bit value to eight bits by copying its top bits below.
    function automatic int wid(input int v, input int n);
        return ((v << (8 - n)) | (v >> (2 * n - 8))) & 255;
    endfunction : wid

    function automatic int sat(input int v);
        return v < 0 ? 0 : v > 255 ? 255 : v;
    endfunction : sat

    // Mode number: 0 differential, 1 T, 2 H, 3 planar.
    function automatic int mode_of(input logic [63:0] b);
        int s [3];
        for (int k = 0; k < 3; k++) s[k] = b[63 - 8 * k -: 5] + int'($signed(b[58 - 8 * k -: 3]));
        return (s[0] < 0 || s[0] > 31) ? 1 : (s[1] < 0 || s[1] > 31) ? 2 :
               (s[2] < 0 || s[2] > 31) ? 3 : 0;
    endfunction : mode_of

    // Reference texel for one block and position.
    function automatic logic [31:0] exp_texel(input logic [63:0] b, input int x, input int y);
        int p, i, mo, t, m, dl, ge, c1 [3], c2 [3], o [3], bs [3];
        p = x * 4 + y;
        i = {b[16 + p], b[p]};
        mo = mode_of(b);
        if (mo == 3) begin
            o = '{wid(b[62:57], 6), wid({b[56], b[54:49]}, 7), wid({b[48], b[44:43], b[41:39]}, 6)};
            c1 = '{wid({b[38:34], b[32]}, 6), wid(b[31:25], 7), wid(b[24:19], 6)};
            c2 = '{wid(b[18:13], 6), wid(b[12:6], 7), wid(b[5:0], 6)};
            for (int k = 0; k < 3; k++) bs[k] = sat((x * (c1[k] - o[k]) + y * (c2[k] - o[k])
                                                      + 4 * o[k] + 2) >>> 2);
            return {bs[0][7:0], bs[1][7:0], bs[2][7:0], 8'hff};
        end
        if (!b[33] && i == 2) return 32'h0;
        if (mo == 0) begin
            t = (b[32] ? y : x) >= 2;
            m = t ? b[36:34] : b[39:37];
            m = i == 1 ? lg[m] : i == 3 ? -lg[m] : !b[33] ? 0 : i == 0 ? sm[m] : -sm[m];
            for (int k = 0; k < 3; k++) bs[k] = sat(m + wid(b[63 - 8 * k -: 5] +
                                             (t ? int'($signed(b[58 - 8 * k -: 3])) : 0), 5));
            return {bs[0][7:0], bs[1][7:0], bs[2][7:0], 8'hff};
        end
        if (mo == 1) begin
            c1 = '{wid({b[60:59], b[57:56]}, 4), wid(b[55:52], 4), wid(b[51:48], 4)};
            c2 = '{wid(b[47:44], 4), wid(b[43:40], 4), wid(b[39:36], 4)};
            dl = dtab[{b[35:34], b[32]}];
        end else begin
            c1 = '{wid(b[62:59], 4), wid({b[58:56], b[52]}, 4), wid({b[51], b[49:47]}, 4)};
            c2 = '{wid(b[46:43], 4), wid(b[42:39], 4), wid(b[38:35], 4)};
            ge = (c1[0] * 65536 + c1[1] * 256 + c1[2]) >= (c2[0] * 65536 + c2[1] * 256 + c2[2]);
            dl = dtab[{b[34], b[32], ge[0]}];
        end
        for (int k = 0; k < 3; k++) bs[k] = mo == 1 ?
            sat((i == 0 ? c1[k] : c2[k]) + (i == 1 ? dl : i == 3 ? -dl : 0)) :
            sat((i < 2 ? c1[k] : c2[k]) + (i[0] ? -dl : dl));
        return {bs[0][7:0], bs[1][7:0], bs[2][7:0], 8'hff};
    endfunction : exp_texel

    // One classic bus cycle; read data lands in rd.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 64);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            $display("Error at %0t: bus answer missing", $time);
        end
    endtask : wb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // Main sequence: registers, enable gating, then a random stream with forced modes.
    initial begin
        int k;
        {reset, wb_cyc_i, wb_stb_i, wb_we_i, stall_en} = 5'b10000;
        {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        wb(0, REG_CTRL, 0, 4'hf);
        chk(rd, 32'h1);
        wb(0, REG_STATUS, 0, 4'hf);
        chk(rd, 32'h10);
        for (k = 0; k < 8; k++) begin
            rd = lfsr();
            dtab[k] = rd[7:0];
            wb(0, REG_DIST_BASE + 8'(4 * k), 0, 4'hf);
            chk(rd, 32'h0);
            wb(1, REG_DIST_BASE + 8'(4 * k), {24'h0, dtab[k]}, 4'hf);
            wb(0, REG_DIST_BASE + 8'(4 * k), 0, 4'hf);
            chk(rd, {24'h0, dtab[k]});
        end
        wb(1, REG_DIST_BASE, 32'h55, 4'he);
        wb(0, REG_DIST_BASE, 0, 4'hf);
        chk(rd, {24'h0, dtab[0]});
        wb(1, 8'h10, 32'hff, 4'hf);
        wb(0, 8'h10, 0, 4'hf);
        chk(rd, 32'h0);
        wb(1, REG_CTRL, 0, 4'hf);
        repeat (3) begin
            @(posedge clock);
            chk(in_ready, 0);
        end
        wb(1, REG_CTRL, 1, 4'hf);
        for (n = 0; n < 240; n++) begin
            rq.block = {lfsr(), lfsr()};
            case (n % 5)
                0: rq.block[63:56] = 8'hf9;
                1: rq.block[63:48] = 16'h00f9;
                2: rq.block[63:40] = 24'h0000f9;
                3: rq.block &= 64'hf8f8f8ffffffffff;
                default: ;
            endcase
            if (n < 2) rq.block = {64{n[0]}};
            rq.x = seed[1:0];
            rq.y = seed[3:2];
            stall_en <= n[5];
            exp_q.push_back(exp_texel(rq.block, rq.x, rq.y));
            i_ptd_sampler_model.send(rq);
            wb(0, REG_STATUS, 0, 4'hf);
            chk({28'h0, rd[7:4]}, 32'h1 << mode_of(rq.block));
        end
        k = 0;
        while (i_ptd_sampler_model.got_q.size() < n && k < 2000) begin
            @(posedge clock);
            k++;
        end
        chk(i_ptd_sampler_model.got_q.size(), n);
        foreach (exp_q[j]) begin
            g = i_ptd_sampler_model.got_q[j];
            e = exp_q[j];
            chk(g[31:8], e[31:8]);
            chk(g, e);
            chk(g, e);
        end
        wb(0, REG_STATUS, 0, 4'hf);
        chk(rd, (32'(n) << 16) | (32'h10 << mode_of(rq.block)));
        end_of_test();
    end
endmodule : ptd_decoder_tb
